/* design/rcd_pkg.sv */
`default_nettype none
package rcd_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000; // System clock rate
   localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int unsigned RX_WAIT_STEP_NS = 9440; // One wait-time step
   // Least time, so round up to whole cycles
   localparam int unsigned RX_WAIT_STEP_CYC =
      (RX_WAIT_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int WAIT_W = 16; // Wait counter width

   ////////////////////////////////////////////////////////////////////////
   // Host word layout
   localparam int WORD_CMD_BIT = 7; // 1 = command, 0 = address
   localparam int WORD_RD_BIT = 6; // Read/write, must be 0 in commands
   localparam int WORD_CONT_BIT = 5; // Continuous address mode
   localparam int ADDR_W = 5; // Register address / command code width

   ////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [4:0] CMD_IDLE = 5'h00;
   localparam logic [4:0] CMD_SOFT_INIT = 5'h03;
   localparam logic [4:0] CMD_RESET_FIFO = 5'h0F;
   localparam logic [4:0] CMD_TX_NO_CRC = 5'h10;
   localparam logic [4:0] CMD_TX_CRC = 5'h11;
   localparam logic [4:0] CMD_BLOCK_RX = 5'h16;
   localparam logic [4:0] CMD_ENABLE_RX = 5'h17;
   localparam logic [4:0] CMD_TEST_INT_RF = 5'h18;
   localparam logic [4:0] CMD_TEST_EXT_RF = 5'h19;
   localparam logic [4:0] CMD_GAIN_ADJ = 5'h1A;

   ////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [4:0] REG_CHIP_CTRL = 5'h00;
   localparam logic [4:0] REG_PROTOCOL_CTRL = 5'h01;
   localparam logic [4:0] REG_OPT_FIRST = 5'h02;
   localparam logic [4:0] REG_RECEIVE_WAIT_TIME = 5'h08;
   localparam logic [4:0] REG_MODULATOR_CLOCK_CONTROL = 5'h09;
   localparam logic [4:0] REG_OPT_LAST = 5'h0B;
   localparam logic [4:0] REG_COLLISION_LOCATION = 5'h0E;
   localparam logic [4:0] REG_SIGNAL_STRENGTH_LEVELS = 5'h0F;
   localparam logic [4:0] REG_FIFO_FILL_STATUS = 5'h1C;
   localparam logic [4:0] REG_TX_LEN1 = 5'h1D;
   localparam logic [4:0] REG_TX_LEN2 = 5'h1E;
   localparam logic [4:0] REG_FIFO_IO = 5'h1F;

   ////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CHIP_DIRECT_BIT = 6; // Enter direct mode
   localparam int CHIP_REC_ON_BIT = 1; // Receiver forced on
   localparam int PROTO_DIRECT1_BIT = 6; // 0 selects direct mode 0
   localparam int RSSI_MAIN_LSB = 0; // Main input code
   localparam int RSSI_AUX_LSB = 3; // Aux input code
   localparam int RSSI_W = 3;
   localparam logic [7:0] CHIP_RST = 8'h01;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] OPT_PRESET = 8'h00; // Protocol default
   localparam logic [7:0] MOD_CLK_KEEP = 8'h30; // Clock divider bits

   ////////////////////////////////////////////////////////////////////////
   // Storage sizes
   localparam int FIFO_DEPTH = 12;
   localparam int CNT_W = 4;
   localparam int OPT_COUNT = 10;
   localparam int BIT_W = 3;
   localparam logic [CNT_W-1:0] FIFO_FULL = 4'hC;
   localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {PH_ADDR, PH_WRITE, PH_READ} rcd_phase_t;

   typedef struct packed {
      logic s1; // First stage, read only by s2
      logic s2;
      logic s3;
      logic stab; // Level accepted once s2 and s3 agree
   } rcd_sync_t;

   typedef struct packed {
      logic start; // One-cycle pulse at start of sending
      logic active; // Transmission in progress
      logic crc_en; // Append generated CRC
      logic valid; // Payload byte offered
      logic [7:0] data; // Payload byte
   } rcd_tx_t;

   typedef struct packed {
      rcd_sync_t ss;
      rcd_sync_t sclk;
      rcd_sync_t mosi;
      rcd_sync_t sub;
      rcd_phase_t phase;
      logic [ADDR_W-1:0] addr;
      logic cont;
      logic [BIT_W-1:0] bitcnt;
      logic [7:0] shin;
      logic [7:0] shout;
      logic skip_fall;
      logic [7:0] chip;
      logic [7:0] proto;
      logic [OPT_COUNT-1:0][7:0] opt;
      logic [7:0] coll;
      logic [7:0] rssi;
      logic [7:0] txlen1;
      logic [7:0] txlen2;
      logic [FIFO_DEPTH-1:0][7:0] fifo;
      logic [CNT_W-1:0] cnt;
      logic tx_pend;
      logic tx_go;
      logic tx_act;
      logic tx_crc;
      logic rx_blk;
      logic [WAIT_W-1:0] wait_cnt;
      logic sub_q;
   } rcd_state_t;
endpackage : rcd_pkg
`default_nettype wire

/* design/rcd_reader_command_decoder.sv */
`default_nettype none
// Functional notes
// - Bit 7 chooses address word or command
// - Address word: read bit, continuous, address
// - Idle does nothing; soft init resets all
// - FIFO reset clears FIFO, status, collision
// - Sending starts on first loaded byte
// - Transmit command appends generated CRC
// - Plain transmit command sends without CRC
// - Block command holds receiver decoder reset
// - Block ends on enable or transmit end
// - Nonzero wait keeps receiver reset longer
// - Enable command releases blocked receiver
// - Internal test stores both signal codes
// - External test needs receiver-force bit
// - Protocol write presets option registers
// - Every protocol reselection reloads defaults
// - Clock divider bits survive protocol select
// - Direct mode 0 passes raw subcarrier out
// - Stop condition returns to normal mode
// - Direct bit enters; stop leaves, clears
module rcd_reader_command_decoder #(
   parameter int unsigned WAIT_STEP_CYC = rcd_pkg::RX_WAIT_STEP_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic ss_n_pin,
   input wire logic sclk_pin,
   input wire logic mosi_pin,
   output logic miso,
   output logic miso_oe,
   input wire logic subcarrier_pin,
   output logic direct_subcarrier_out,
   output logic direct_subcarrier_oe,
   output logic direct_mode,
   output logic rx_decoder_reset,
   output rcd_pkg::rcd_tx_t tx,
   input wire logic tx_ready,
   input wire logic tx_done,
   input wire logic [2:0] rssi_main_code,
   input wire logic [2:0] rssi_aux_code,
   input wire logic coll_load,
   input wire logic [7:0] coll_value,
   output logic [7:0] chip_ctrl,
   output logic [7:0] protocol_ctrl
);

   ////////////////////////////////////////////////////////////////////////
   // State and decode helpers
   rcd_pkg::rcd_state_t q; // Registered state
   rcd_pkg::rcd_state_t d; // Next state
   logic sclk_rise; // Accepted rising edge of serial clock
   logic sclk_fall; // Accepted falling edge
   logic stop_cond; // Select rose: stop condition
   logic word_done; // Eighth bit of a word taken
   logic [7:0] word; // Completed word
   logic cmd_fire; // Valid-form command word arrived
   logic [4:0] cmd_code; // Its code
   logic direct0; // Direct mode 0 active
   localparam int WAIT_W_L = rcd_pkg::WAIT_W; // Wait counter width
   localparam int CNT_W_L = rcd_pkg::CNT_W; // FIFO count width
   logic [WAIT_W_L-1:0] wait_load; // Receiver wait in cycles

   localparam logic [WAIT_W_L-1:0] WAIT_STEP = WAIT_W_L'(WAIT_STEP_CYC);

   // Next accepted level: changes once stages two and three agree
   function automatic logic sync_stab(input rcd_pkg::rcd_sync_t s);
      sync_stab = (s.s2 == s.s3) ? s.s3 : s.stab;
   endfunction : sync_stab

   // Shift one pin sample through a synchroniser
   function automatic rcd_pkg::rcd_sync_t sync_step(
      input rcd_pkg::rcd_sync_t s, input logic pin);
      rcd_pkg::rcd_sync_t r;
      r.s1 = pin;
      r.s2 = s.s1;
      r.s3 = s.s2;
      r.stab = sync_stab(s);
      sync_step = r;
   endfunction : sync_step

   // Register read mux, shared by single and continuous reads
   function automatic logic [7:0] reg_read(
      input rcd_pkg::rcd_state_t s, input logic [4:0] a);
      logic [4:0] k;
      k = a - rcd_pkg::REG_OPT_FIRST;
      reg_read = rcd_pkg::REG_RST;
      if (a == rcd_pkg::REG_CHIP_CTRL) begin
         reg_read = s.chip;
      end else if (a == rcd_pkg::REG_PROTOCOL_CTRL) begin
         reg_read = s.proto;
      end else if (a >= rcd_pkg::REG_OPT_FIRST &&
                   a <= rcd_pkg::REG_OPT_LAST) begin
         reg_read = s.opt[k[3:0]];
      end else if (a == rcd_pkg::REG_COLLISION_LOCATION) begin
         reg_read = s.coll;
      end else if (a == rcd_pkg::REG_SIGNAL_STRENGTH_LEVELS) begin
         reg_read = s.rssi;
      end else if (a == rcd_pkg::REG_FIFO_FILL_STATUS) begin
         reg_read = {4'h0, s.cnt};
      end else if (a == rcd_pkg::REG_TX_LEN1) begin
         reg_read = s.txlen1;
      end else if (a == rcd_pkg::REG_TX_LEN2) begin
         reg_read = s.txlen2;
      end else if (a == rcd_pkg::REG_FIFO_IO) begin
         reg_read = s.fifo[0];
      end
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////
   // Edge and word decode
   assign sclk_rise = sync_stab(q.sclk) & ~q.sclk.stab;
   assign sclk_fall = ~sync_stab(q.sclk) & q.sclk.stab;
   assign stop_cond = sync_stab(q.ss) & ~q.ss.stab;
   assign word = {q.shin[6:0], q.mosi.stab};
   assign word_done = ~q.ss.stab & sclk_rise & (q.bitcnt == rcd_pkg::LAST_BIT)
                      & ~q.chip[rcd_pkg::CHIP_DIRECT_BIT];
   // Command only from address phase with bit 7 high, bit 6 low
   assign cmd_fire = word_done & (q.phase == rcd_pkg::PH_ADDR)
                     & word[rcd_pkg::WORD_CMD_BIT]
                     & ~word[rcd_pkg::WORD_RD_BIT];
   assign cmd_code = word[4:0];
   assign direct0 = q.chip[rcd_pkg::CHIP_DIRECT_BIT]
                    & ~q.proto[rcd_pkg::PROTO_DIRECT1_BIT];
   assign wait_load = WAIT_W_L'(q.opt[3'h6] * WAIT_STEP);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic pop; // One byte leaves the FIFO
      logic push; // One byte enters the FIFO
      logic [7:0] push_val;
      logic [4:0] k;
      logic [CNT_W_L-1:0] wr_at;
      d = q;
      pop = 1'b0;
      push = 1'b0;
      push_val = 8'h00;
      k = q.addr - rcd_pkg::REG_OPT_FIRST;
      wr_at = q.cnt;
      d.tx_go = 1'b0;
      // Pin synchronisers
      d.ss = sync_step(q.ss, ss_n_pin);
      d.sclk = sync_step(q.sclk, sclk_pin);
      d.mosi = sync_step(q.mosi, mosi_pin);
      d.sub = sync_step(q.sub, subcarrier_pin);
      // Raw subcarrier to the I/O pin in direct mode 0
      d.sub_q = direct0 & q.sub.stab;
      // Serial framing
      if (q.ss.stab) begin
         d.bitcnt = '0;
         d.phase = rcd_pkg::PH_ADDR;
      end else if (sclk_rise) begin
         d.shin = word;
         d.bitcnt = q.bitcnt + 3'h1;
      end else if (sclk_fall) begin
         // Hold the first bit one falling edge after a load
         if (q.skip_fall) begin
            d.skip_fall = 1'b0;
         end else begin
            d.shout = {q.shout[6:0], 1'b0};
         end
      end
      // Stop condition ends direct mode
      if (stop_cond) begin
         d.chip[rcd_pkg::CHIP_DIRECT_BIT] = 1'b0;
      end
      // Completed words
      if (word_done) begin
         unique case (q.phase)
            rcd_pkg::PH_ADDR: begin
               if (!word[rcd_pkg::WORD_CMD_BIT]) begin
                  // Address word
                  d.addr = word[4:0];
                  d.cont = word[rcd_pkg::WORD_CONT_BIT];
                  if (word[rcd_pkg::WORD_RD_BIT]) begin
                     d.phase = rcd_pkg::PH_READ;
                     d.shout = reg_read(q, word[4:0]);
                     d.skip_fall = 1'b1;
                     pop = (word[4:0] == rcd_pkg::REG_FIFO_IO) && q.cnt != 0;
                  end else begin
                     d.phase = rcd_pkg::PH_WRITE;
                  end
               end
            end
            rcd_pkg::PH_WRITE: begin
               // Register write
               if (q.addr == rcd_pkg::REG_CHIP_CTRL) begin
                  d.chip = word;
               end else if (q.addr == rcd_pkg::REG_PROTOCOL_CTRL) begin
                  d.proto = word;
                  // Any protocol write reloads every option default
                  for (int i = 0; i < rcd_pkg::OPT_COUNT; i++) begin
                     d.opt[i] = rcd_pkg::OPT_PRESET;
                  end
                  // Clock divider bits are kept
                  d.opt[3'h7] = (q.opt[3'h7] & rcd_pkg::MOD_CLK_KEEP)
                     | (rcd_pkg::OPT_PRESET & ~rcd_pkg::MOD_CLK_KEEP);
               end else if (q.addr >= rcd_pkg::REG_OPT_FIRST &&
                            q.addr <= rcd_pkg::REG_OPT_LAST) begin
                  d.opt[k[3:0]] = word;
               end else if (q.addr == rcd_pkg::REG_TX_LEN1) begin
                  d.txlen1 = word;
               end else if (q.addr == rcd_pkg::REG_TX_LEN2) begin
                  d.txlen2 = word;
               end else if (q.addr == rcd_pkg::REG_FIFO_IO) begin
                  push = q.cnt != rcd_pkg::FIFO_FULL;
                  push_val = word;
               end
               // Continuous mode walks on, else back to address
               if (q.cont) begin
                  d.addr = q.addr + 5'h01;
               end else begin
                  d.phase = rcd_pkg::PH_ADDR;
               end
            end
            rcd_pkg::PH_READ: begin
               if (q.cont) begin
                  d.addr = q.addr + 5'h01;
                  d.shout = reg_read(q, q.addr + 5'h01);
                  d.skip_fall = 1'b1;
                  pop = (q.addr + 5'h01 == rcd_pkg::REG_FIFO_IO) &&
                        q.cnt != 0;
               end else begin
                  d.phase = rcd_pkg::PH_ADDR;
               end
            end
            default: begin
               d.phase = rcd_pkg::PH_ADDR;
            end
         endcase
      end
      // Direct commands
      if (cmd_fire) begin
         unique case (cmd_code)
            rcd_pkg::CMD_IDLE: begin
               d.tx_go = 1'b0;
            end
            rcd_pkg::CMD_SOFT_INIT: begin
               // Same effect as power-on reset of the reader
               d.chip = rcd_pkg::CHIP_RST;
               d.proto = rcd_pkg::REG_RST;
               d.opt = '0;
               d.coll = rcd_pkg::REG_RST;
               d.rssi = rcd_pkg::REG_RST;
               d.txlen1 = rcd_pkg::REG_RST;
               d.txlen2 = rcd_pkg::REG_RST;
               d.cnt = '0;
               d.tx_pend = 1'b0;
               d.tx_act = 1'b0;
               d.tx_crc = 1'b0;
               d.rx_blk = 1'b0;
               d.wait_cnt = '0;
            end
            rcd_pkg::CMD_RESET_FIFO: begin
               d.cnt = '0;
               d.coll = rcd_pkg::REG_RST;
            end
            rcd_pkg::CMD_TX_NO_CRC: begin
               d.tx_pend = 1'b1;
               d.tx_crc = 1'b0;
            end
            rcd_pkg::CMD_TX_CRC: begin
               d.tx_pend = 1'b1;
               d.tx_crc = 1'b1;
            end
            rcd_pkg::CMD_BLOCK_RX: begin
               d.rx_blk = 1'b1;
            end
            rcd_pkg::CMD_ENABLE_RX: begin
               d.rx_blk = 1'b0;
               d.wait_cnt = '0;
            end
            rcd_pkg::CMD_TEST_INT_RF: begin
               d.rssi = rcd_pkg::REG_RST;
               d.rssi[rcd_pkg::RSSI_MAIN_LSB +: rcd_pkg::RSSI_W] =
                  rssi_main_code;
               d.rssi[rcd_pkg::RSSI_AUX_LSB +: rcd_pkg::RSSI_W] =
                  rssi_aux_code;
            end
            rcd_pkg::CMD_TEST_EXT_RF: begin
               // Only with the receiver forced on
               if (q.chip[rcd_pkg::CHIP_REC_ON_BIT]) begin
                  d.rssi = rcd_pkg::REG_RST;
                  d.rssi[rcd_pkg::RSSI_MAIN_LSB +: rcd_pkg::RSSI_W] =
                     rssi_main_code;
               end
            end
            rcd_pkg::CMD_GAIN_ADJ: begin
               d.tx_go = 1'b0;
            end
            default: begin
               d.tx_go = 1'b0;
            end
         endcase
      end
      // Start sending once the first payload byte is present
      if (q.tx_pend && q.cnt != 0) begin
         d.tx_pend = 1'b0;
         d.tx_act = 1'b1;
         d.tx_go = 1'b1;
      end
      // Transmitter drains the FIFO
      if (q.tx_act && tx_ready && q.cnt != 0 && !pop) begin
         pop = 1'b1;
      end
      // End of transmit releases the block, maybe after a wait
      if (q.tx_act && tx_done) begin
         d.tx_act = 1'b0;
         d.rx_blk = 1'b0;
         d.wait_cnt = wait_load;
      end else if (q.wait_cnt != 0) begin
         d.wait_cnt = q.wait_cnt - 16'h0001;
      end
      // FIFO update, pop before push
      if (pop) begin
         for (int i = 0; i < rcd_pkg::FIFO_DEPTH - 1; i++) begin
            d.fifo[i] = q.fifo[i+1];
         end
         wr_at = q.cnt - 4'h1;
      end
      if (push) begin
         d.fifo[wr_at] = push_val;
      end
      if (!(cmd_fire && (cmd_code == rcd_pkg::CMD_RESET_FIFO ||
                         cmd_code == rcd_pkg::CMD_SOFT_INIT))) begin
         d.cnt = wr_at + CNT_W_L'(push);
      end
      // Soft init wins over transmit bookkeeping
      if (cmd_fire && cmd_code == rcd_pkg::CMD_SOFT_INIT) begin
         d.tx_pend = 1'b0;
         d.tx_act = 1'b0;
         d.tx_go = 1'b0;
         d.rx_blk = 1'b0;
      end
      // Init or enable also cancels a running wait
      if (cmd_fire && (cmd_code == rcd_pkg::CMD_SOFT_INIT ||
                       cmd_code == rcd_pkg::CMD_ENABLE_RX)) begin
         d.wait_cnt = '0;
      end
      // Collision capture wins over the clear
      if (coll_load) begin
         d.coll = coll_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= '0;
         q.ss <= '1;
         q.chip <= rcd_pkg::CHIP_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign miso = q.shout[7];
   assign miso_oe = ~q.ss.stab & (q.phase == rcd_pkg::PH_READ);
   assign direct_subcarrier_out = q.sub_q;
   assign direct_subcarrier_oe = direct0;
   assign direct_mode = q.chip[rcd_pkg::CHIP_DIRECT_BIT];
   assign rx_decoder_reset = q.rx_blk | (q.wait_cnt != 0);
   assign tx.start = q.tx_go;
   assign tx.active = q.tx_act;
   assign tx.crc_en = q.tx_crc;
   assign tx.valid = q.tx_act & (q.cnt != 0);
   assign tx.data = q.fifo[0];
   assign chip_ctrl = q.chip;
   assign protocol_ctrl = q.proto;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence cmd_s(logic [4:0] c);
      ce && cmd_fire && cmd_code == c;
   endsequence

   fifo_reset_a: assert property (cmd_s(rcd_pkg::CMD_RESET_FIFO) && !coll_load
      |=> q.cnt == 0 && q.coll == 8'h00)
      else $error("fifo reset left data or collision");
   soft_init_a: assert property (cmd_s(rcd_pkg::CMD_SOFT_INIT)
      |=> q.chip == rcd_pkg::CHIP_RST && !rx_decoder_reset)
      else $error("soft init did not restore defaults");
   crc_sel_a: assert property (cmd_s(rcd_pkg::CMD_TX_CRC)
      |=> tx.crc_en)
      else $error("crc transmit without crc enable");
   nocrc_sel_a: assert property (cmd_s(rcd_pkg::CMD_TX_NO_CRC)
      |=> !tx.crc_en)
      else $error("plain transmit with crc enable");
   tx_start_a: assert property (ce && q.tx_pend && q.cnt != 0
      |=> tx.start && tx.active ##1 !tx.start)
      else $error("send did not start on first byte");
   block_rx_a: assert property (cmd_s(rcd_pkg::CMD_BLOCK_RX)
      |=> rx_decoder_reset)
      else $error("block command left receiver free");
   enable_rx_a: assert property (cmd_s(rcd_pkg::CMD_ENABLE_RX)
      && !(q.tx_act && tx_done) |=> !rx_decoder_reset)
      else $error("enable command left receiver reset");
   wait_hold_a: assert property (ce && q.tx_act && tx_done && q.opt[3'h6] != 0
      |=> rx_decoder_reset)
      else $error("receiver released before wait time");
   int_rf_a: assert property (cmd_s(rcd_pkg::CMD_TEST_INT_RF)
      |=> q.rssi[2:0] == $past(rssi_main_code)
      && q.rssi[5:3] == $past(rssi_aux_code))
      else $error("internal field codes not stored");
   clk_keep_a: assert property (ce && word_done && q.phase == rcd_pkg::PH_WRITE
      && q.addr == rcd_pkg::REG_PROTOCOL_CTRL
      |=> (q.opt[3'h7] & rcd_pkg::MOD_CLK_KEEP)
      == ($past(q.opt[3'h7]) & rcd_pkg::MOD_CLK_KEEP)
      && q.opt[3'h6] == rcd_pkg::OPT_PRESET)
      else $error("protocol preset wrong");
   stop_exit_a: assert property (ce && stop_cond |=> !direct_mode)
      else $error("stop did not leave direct mode");
   unknown_a: assert property (ce && cmd_fire && cmd_code == 5'h05
      && !q.tx_pend && !(q.tx_act && tx_done)
      |=> $stable(q.rx_blk) && $stable(q.rssi))
      else $error("unknown command changed state");
endmodule : rcd_reader_command_decoder
`default_nettype wire

/* verification/rcd_host_model.sv */
`default_nettype none
// Host side of the serial port: slow SPI, MSB first
module rcd_host_model (
   input wire logic mclk,
   input wire logic miso,
   output logic ss_n_pin,
   output logic sclk_pin,
   output logic mosi_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus: deselected, clock low
   initial begin
      ss_n_pin = 1'b1;
      sclk_pin = 1'b0;
      mosi_pin = 1'b0;
   end
   // Half SPI period, long enough for the pin synchronisers
   task automatic half;
      repeat (8) @(negedge mclk);
   endtask : half
   // One byte; data changes low, miso taken at each rise
   task automatic xfer(input logic [7:0] w, output logic [7:0] r);
      ss_n_pin <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_pin <= w[i];
         half();
         sclk_pin <= 1'b1;
         r[i] = miso;
         half();
         sclk_pin <= 1'b0;
      end
   endtask : xfer
   // Stop condition ends the frame
   task automatic stop;
      half();
      ss_n_pin <= 1'b1;
      half();
   endtask : stop
endmodule : rcd_host_model
`default_nettype wire

/* verification/reader_command_decoder_test.sv */
`default_nettype none
module reader_command_decoder_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic ss_n, sclk, mosi, miso, miso_oe, dso, doe, dmode, rxr;
   logic sub = 1'b0;
   logic tx_ready = 1'b0;
   logic tx_done = 1'b0;
   logic [2:0] rm = 3'h0;
   logic [2:0] ra = 3'h0;
   logic cl = 1'b0;
   logic [7:0] cv = 8'h00;
   logic [7:0] chip, proto, v;
   rcd_pkg::rcd_tx_t tx;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   // Rows: write addr, data, read addr, expected
   logic [25:0] rows [7] = '{
      {5'h08, 8'h05, 5'h08, 8'h05},
      {5'h0E, 8'hFF, 5'h0E, 8'h00},
      {5'h09, 8'h3F, 5'h09, 8'h3F},
      {5'h01, 8'h08, 5'h09, 8'h30},
      {5'h08, 8'h05, 5'h08, 8'h05},
      {5'h01, 8'h08, 5'h08, 8'h00},
      {5'h15, 8'hAA, 5'h15, 8'h00}};
   rcd_reader_command_decoder #(.WAIT_STEP_CYC(2)) uut (.mclk(mclk),
      .rst_n(rst_n), .ce(ce), .ss_n_pin(ss_n), .sclk_pin(sclk),
      .mosi_pin(mosi), .miso(miso), .miso_oe(miso_oe),
      .subcarrier_pin(sub), .direct_subcarrier_out(dso),
      .direct_subcarrier_oe(doe), .direct_mode(dmode),
      .rx_decoder_reset(rxr), .tx(tx), .tx_ready(tx_ready),
      .tx_done(tx_done), .rssi_main_code(rm), .rssi_aux_code(ra),
      .coll_load(cl), .coll_value(cv), .chip_ctrl(chip),
      .protocol_ctrl(proto));
   rcd_host_model host (.mclk(mclk), .miso(miso), .ss_n_pin(ss_n),
      .sclk_pin(sclk), .mosi_pin(mosi));
   always #25 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test;
      if (err_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string s, input logic [7:0] a, e);
      n_compared++;
      if (a !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, a);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({3'h0, a}, v);
      host.xfer(d, v);
      host.stop();
   endtask : wr
   task automatic rchk(input logic [4:0] a, input logic [7:0] e);
      host.xfer({3'h2, a}, v);
      host.xfer(8'h00, v);
      host.stop();
      check($sformatf("reg %h", a), v, e);
   endtask : rchk
   // Command word keeps bit 6 low
   task automatic cmd(input logic [4:0] c);
      host.xfer({3'h4, c}, v);
      host.stop();
   endtask : cmd
   // Main sequence
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      check("reset", {chip[6:0], rxr}, 8'h02);
      check("oe", miso_oe, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i][25:21], rows[i][20:13]);
         rchk(rows[i][12:8], rows[i][7:0]);
      end
      check("proto", proto, 8'h08);
      cmd(5'h17);
      rm = 3'h3;
      ra = 3'h5;
      cmd(5'h18);
      rchk(5'h0F, 8'h2B);
      rm = 3'h6;
      cmd(5'h19);
      rchk(5'h0F, 8'h2B);
      wr(5'h00, 8'h03);
      cmd(5'h19);
      check("ext", chip, 8'h03);
      rchk(5'h0F, 8'h06);
      cmd(5'h05);
      cmd(5'h00);
      check("idle", chip, 8'h03);
      cmd(5'h03);
      check("init", chip, 8'h01);
      wr(5'h08, 8'h01);
      for (int j = 0; j < 2; j++) begin
         cmd(5'h16);
         check("block", rxr, 8'h01);
         cmd(5'h11 - j[4:0]);
         wr(5'h1D, 8'h00);
         wr(5'h1F, 8'hA5);
         check("tx", {tx.active, tx.valid, tx.crc_en},
            8'h07 - j[7:0]);
         check("txd", tx.data, 8'hA5);
         tx_ready = 1'b1;
         @(negedge mclk);
         tx_ready = 1'b0;
         tx_done = 1'b1;
         @(negedge mclk);
         tx_done = 1'b0;
         check("wait", rxr, 8'h01);
         repeat (4) @(negedge mclk);
         check("free", rxr, 8'h00);
      end
      cmd(5'h16);
      cmd(5'h17);
      check("enable", rxr, 8'h00);
      cv = 8'h5A;
      cl = 1'b1;
      @(negedge mclk);
      cl = 1'b0;
      wr(5'h1F, 8'h11);
      rchk(5'h0E, 8'h5A);
      rchk(5'h1C, 8'h01);
      cmd(5'h0F);
      rchk(5'h1C, 8'h00);
      rchk(5'h0E, 8'h00);
      sub = 1'b1;
      host.xfer(8'h00, v);
      host.xfer(8'h40, v);
      repeat (6) @(negedge mclk);
      check("direct", {dmode, doe, dso}, 8'h07);
      // Raw level follows the pin for the host to decode
      sub = 1'b0;
      repeat (6) @(negedge mclk);
      check("raw", dso, 8'h00);
      host.stop();
      check("normal", {dmode, doe}, 8'h00);
      check("chip", chip, 8'h00);
      stop_test();
   end
endmodule : reader_command_decoder_test
`default_nettype wire
